// ===== core/dvd_core.sv
// Data value compare and taken-branch debug event detection.
// Assumes the pipeline presents one storage access and one branch per
// cycle, with address compare hits already resolved per comparator.
`timescale 1ns/1ps

// How it works
// - Value event needs address compare hit plus a value match.
// - Two comparators, each with its own four-byte reference word.
// - Value event sets the comparator read or write status flag.
// - All-zero lane enables disable that value event; nonzero enables it in AND, OR or AND-OR mode.
// - Enable bit i selects byte lane i; lane 0 is the top byte.
// - A lane matches only if transferred and equal to reference byte.
// - Only lanes of the aligned word holding the start byte count.
// - AND mode: every enabled lane accessed and matching.
// - OR mode: any enabled lane accessed and matching.
// - AND-OR mode: AND on lanes 0-1 or on lanes 2-3.
// - Async select picks precise or imprecise value event reporting.
// - Each storage access of an instruction is checked on its own.
// - Only the zero-line store among cache ops may match; data zero.
// - Failed conditional store raises no value write event.
// - Branch enable set: a taken branch raises a branch event in external, wait, irq-allowed internal or trace mode.
// - External or wait mode: flag, suppress, stop at branch address.
// - Internal mode with irq allowed, external and wait off: flag, suppress, irq, save pc.
// - Internal-only mode with irq disallowed: no branch event.
// - Trace mode with no external, wait or irq-allowed internal mode: flag and trace pulse, execution continues.
module dvd_core
  import dvd_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Storage access from the load/store pipe
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [1:0] acc_offset,
  input wire logic [2:0] acc_size,
  input wire logic [DATA_W-1:0] acc_data,
  input wire logic acc_zero_line,
  input wire logic acc_cache_op,
  input wire logic acc_no_reserve,
  input wire logic acc_string_empty,
  input wire logic addr_hit1,
  input wire logic addr_hit2,
  // Branch from the branch pipe
  input wire logic br_valid,
  input wire logic br_taken,
  input wire logic [31:0] br_pc,
  input wire logic break_irq_allow,
  // Event outputs
  output logic data_value_match1,
  output logic data_value_match2,
  output logic value_precise,
  output logic taken_branch_event,
  output logic branch_suppress,
  output logic stop_request,
  output logic debug_irq,
  output logic trace_event,
  output logic [31:0] critical_return_pc
);

  // ==========================================================
  // Registers
  logic [31:0] debug_control_zero_reg;
  logic [31:0] debug_control_two_reg;
  logic [31:0] value_reference_one_reg;
  logic [31:0] value_reference_two_reg;
  logic [ST_W-1:0] debug_status_reg;

  // Field views
  logic [3:0] cmp1_lane_enables;
  logic [3:0] cmp2_lane_enables;
  dvd_mode_t cmp1_match_mode;
  dvd_mode_t cmp2_match_mode;
  logic compare_async_select;
  logic branch_enable;
  logic ext_debug;
  logic wait_mode;
  logic int_debug;
  logic trace_mode;

  assign cmp1_lane_enables = debug_control_two_reg[C2_LANES1 +: 4];
  assign cmp2_lane_enables = debug_control_two_reg[C2_LANES2 +: 4];
  assign cmp1_match_mode = dvd_mode_t'(debug_control_two_reg[C2_MODE1 +: 2]);
  assign cmp2_match_mode = dvd_mode_t'(debug_control_two_reg[C2_MODE2 +: 2]);
  assign compare_async_select = debug_control_two_reg[C2_ASYNC];
  assign branch_enable = debug_control_zero_reg[C0_BRANCH_EN];
  assign ext_debug = debug_control_zero_reg[C0_EXT_DEBUG];
  assign wait_mode = debug_control_zero_reg[C0_WAIT_MODE];
  assign int_debug = debug_control_zero_reg[C0_INT_DEBUG];
  assign trace_mode = debug_control_zero_reg[C0_TRACE];

  // ==========================================================
  // Lane compare function
  // Lane i is byte i of the aligned word, lane 0 the top byte.
  function automatic logic lane_rule(input logic [3:0] en,
                                     input logic [3:0] hit,
                                     input dvd_mode_t mode);
    logic all_ok;
    logic any_ok;
    logic pair_lo;
    logic pair_hi;
    all_ok = (en != 4'h0) && ((~en | hit) == 4'hF);
    any_ok = ((en & hit) != 4'h0);
    pair_lo = (en[1:0] != 2'h0) && ((~en[1:0] | hit[1:0]) == 2'h3);
    pair_hi = (en[3:2] != 2'h0) && ((~en[3:2] | hit[3:2]) == 2'h3);
    lane_rule = 1'b0;
    if (en == 4'h0) begin
      lane_rule = 1'b0;
    end else begin
      case (mode)
        DVD_MODE_AND: lane_rule = all_ok;
        DVD_MODE_OR: lane_rule = any_ok;
        DVD_MODE_ANDOR: lane_rule = pair_lo | pair_hi;
        default: lane_rule = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // Access qualification and lane masks
  logic [3:0] lane_used;
  logic [DATA_W-1:0] cmp_data;
  logic acc_ok;
  logic [3:0] hit1;
  logic [3:0] hit2;
  logic vmatch1;
  logic vmatch2;

  // Lanes from the start byte to the last byte moved, within its aligned word only
  always_comb begin
    logic [3:0] last;
    last = 4'h0;
    lane_used = 4'h0;
    last = 4'({2'b00, acc_offset}) + 4'({1'b0, acc_size}) - 4'h1;
    for (int i = 0; i < 4; i++) begin
      if ((4'(i) >= 4'({2'b00, acc_offset})) && (4'(i) <= last) &&
          (acc_size != 3'h0)) begin
        lane_used[i] = 1'b1;
      end
    end
  end

  // Zero-line store writes zeros whatever the data bus holds
  assign cmp_data = acc_zero_line ? '0 : acc_data;

  // Each access stands alone; no instruction-level merging
  assign acc_ok = acc_valid && !acc_string_empty &&
                  !(acc_cache_op && !acc_zero_line) &&
                  !(acc_write && acc_no_reserve);

  // Per-lane equality against both references
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hit1[i] = lane_used[i] &&
        (cmp_data[31-8*i -: 8] == value_reference_one_reg[31-8*i -: 8]);
      hit2[i] = lane_used[i] &&
        (cmp_data[31-8*i -: 8] == value_reference_two_reg[31-8*i -: 8]);
    end
  end

  // Address compare must already hold for the same access
  assign vmatch1 = acc_ok && addr_hit1 &&
                   lane_rule(cmp1_lane_enables, hit1, cmp1_match_mode);
  assign vmatch2 = acc_ok && addr_hit2 &&
                   lane_rule(cmp2_lane_enables, hit2, cmp2_match_mode);

  // ==========================================================
  // Value event outputs
  // Precise when the async select is clear; the flag is registered
  // with the value event, one cycle after the access.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_value_match1 <= 1'b0;
      data_value_match2 <= 1'b0;
      value_precise <= 1'b0;
    end else begin
      data_value_match1 <= vmatch1;
      data_value_match2 <= vmatch2;
      value_precise <= (vmatch1 | vmatch2) && !compare_async_select;
    end
  end

  // ==========================================================
  // Taken-branch event
  logic br_event;
  logic br_halt_mode;
  logic br_irq_mode;

  assign br_halt_mode = ext_debug | wait_mode;
  assign br_irq_mode = int_debug && break_irq_allow && !br_halt_mode;
  // Internal mode without irq permission never qualifies
  assign br_event = branch_enable && br_valid && br_taken &&
                    (br_halt_mode | br_irq_mode | trace_mode);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_branch_event <= 1'b0;
      branch_suppress <= 1'b0;
      stop_request <= 1'b0;
      debug_irq <= 1'b0;
      trace_event <= 1'b0;
    end else begin
      taken_branch_event <= br_event;
      branch_suppress <= br_event && (br_halt_mode | br_irq_mode);
      stop_request <= br_event && br_halt_mode;
      debug_irq <= br_event && br_irq_mode;
      // Trace alone lets the branch run
      trace_event <= br_event && trace_mode;
    end
  end

  // Return address is the branch itself, not its target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      critical_return_pc <= RST_WORD;
    end else if (br_event && br_irq_mode) begin
      critical_return_pc <= br_pc;
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  logic wr_go;
  logic [3:0] wr_sel;
  logic wr_mapped;
  logic [31:0] wmask;

  // Address and data are taken together, one write at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{s_axi_wstrb[i]}};
    end
  end

  always_comb begin
    wr_sel = 4'h0;
    wr_mapped = 1'b1;
    if (s_axi_awaddr == OFS_CTRL0) begin
      wr_sel = 4'h1;
    end else if (s_axi_awaddr == OFS_CTRL2) begin
      wr_sel = 4'h2;
    end else if (s_axi_awaddr == OFS_REF1) begin
      wr_sel = 4'h4;
    end else if (s_axi_awaddr == OFS_REF2) begin
      wr_sel = 4'h8;
    end else if (s_axi_awaddr != OFS_STATUS) begin
      wr_mapped = 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      debug_control_zero_reg <= RST_WORD;
      debug_control_two_reg <= RST_WORD;
      value_reference_one_reg <= RST_WORD;
      value_reference_two_reg <= RST_WORD;
    end else if (wr_go) begin
      if (wr_sel[0]) begin
        debug_control_zero_reg <= ((debug_control_zero_reg & ~wmask) |
                                   (s_axi_wdata & wmask)) & C0_MASK;
      end
      if (wr_sel[1]) begin
        debug_control_two_reg <= ((debug_control_two_reg & ~wmask) |
                                  (s_axi_wdata & wmask)) & C2_MASK;
      end
      if (wr_sel[2]) begin
        value_reference_one_reg <= (value_reference_one_reg & ~wmask) |
                                   (s_axi_wdata & wmask);
      end
      if (wr_sel[3]) begin
        value_reference_two_reg <= (value_reference_two_reg & ~wmask) |
                                   (s_axi_wdata & wmask);
      end
    end
  end

  // ==========================================================
  // Status flags: sticky, write one to clear, set beats clear
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;

  always_comb begin
    st_set = '0;
    st_set[ST_CMP1_RD] = vmatch1 && !acc_write;
    st_set[ST_CMP1_WR] = vmatch1 && acc_write;
    st_set[ST_CMP2_RD] = vmatch2 && !acc_write;
    st_set[ST_CMP2_WR] = vmatch2 && acc_write;
    st_set[ST_BRANCH] = br_event;
    st_clr = '0;
    if (wr_go && (s_axi_awaddr == OFS_STATUS) && s_axi_wstrb[0]) begin
      st_clr = s_axi_wdata[ST_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      debug_status_reg <= '0;
    end else begin
      debug_status_reg <= (debug_status_reg & ~st_clr) | st_set;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  logic rd_go;
  logic [31:0] rd_word;
  logic rd_mapped;

  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;

  always_comb begin
    rd_word = RST_WORD;
    rd_mapped = 1'b1;
    if (s_axi_araddr == OFS_CTRL0) begin
      rd_word = debug_control_zero_reg;
    end else if (s_axi_araddr == OFS_CTRL2) begin
      rd_word = debug_control_two_reg;
    end else if (s_axi_araddr == OFS_REF1) begin
      rd_word = value_reference_one_reg;
    end else if (s_axi_araddr == OFS_REF2) begin
      rd_word = value_reference_two_reg;
    end else if (s_axi_araddr == OFS_STATUS) begin
      rd_word = {{(32-ST_W){1'b0}}, debug_status_reg};
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // Read data is held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RST_WORD;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== core/dvd_pkg.sv
// Constants for the data value and taken-branch debug event block.
// Assumes a 32-bit AXI4-Lite register bus and a 25 MHz core clock.
package dvd_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_REF1 = 8'h08;
  localparam logic [7:0] OFS_REF2 = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int ADDR_W = 8;
  // ==========================================================
  // debug_control_zero fields
  localparam int C0_BRANCH_EN = 0;
  localparam int C0_EXT_DEBUG = 1;
  localparam int C0_WAIT_MODE = 2;
  localparam int C0_INT_DEBUG = 3;
  localparam int C0_TRACE = 4;
  localparam logic [31:0] C0_MASK = 32'h0000001F;
  // ==========================================================
  // debug_control_two fields
  localparam int C2_LANES1 = 0;
  localparam int C2_LANES2 = 4;
  localparam int C2_MODE1 = 8;
  localparam int C2_MODE2 = 10;
  localparam int C2_ASYNC = 12;
  localparam logic [31:0] C2_MASK = 32'h00001FFF;
  // ==========================================================
  // debug_status_reg fields
  localparam int ST_CMP1_RD = 0;
  localparam int ST_CMP1_WR = 1;
  localparam int ST_CMP2_RD = 2;
  localparam int ST_CMP2_WR = 3;
  localparam int ST_BRANCH = 4;
  localparam int ST_W = 5;
  // ==========================================================
  // Reset values and bus answers
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Value compare modes
  typedef enum logic [1:0] {
    DVD_MODE_OFF = 2'b00,
    DVD_MODE_AND = 2'b01,
    DVD_MODE_OR = 2'b10,
    DVD_MODE_ANDOR = 2'b11
  } dvd_mode_t;
endpackage

// ===== dv/dvd_pipe_model.sv
// Pipeline model: one storage access and one branch per cycle.
// Assumes the bench calls put and idle from its main sequence.
`timescale 1ns/1ps
module dvd_pipe_model (
  // Clock
  input wire logic aclk,
  // Access and branch towards the core
  output logic acc_valid,
  output logic br_valid,
  output logic acc_write,
  output logic [1:0] acc_offset,
  output logic [2:0] acc_size,
  output logic acc_zero_line,
  output logic acc_cache_op,
  output logic acc_no_reserve,
  output logic acc_string_empty,
  output logic addr_hit1,
  output logic addr_hit2,
  output logic br_taken,
  output logic [31:0] acc_data,
  output logic [31:0] br_pc
);
  // ==========================================================
  // One word holds every field, so a cycle changes them together
  logic [78:0] cur_reg = '0;
  assign {acc_valid, br_valid, acc_write, acc_offset, acc_size,
          acc_zero_line, acc_cache_op, acc_no_reserve, acc_string_empty,
          addr_hit1, addr_hit2, br_taken, acc_data, br_pc} = cur_reg;
  // Each access of an instruction goes out as its own cycle
  task put(input logic [78:0] v);
    @(posedge aclk);
    cur_reg <= v;
  endtask
  // Valids drop; payload inverted so stale data never passes as a match
  task idle;
    @(posedge aclk);
    cur_reg <= {2'h0, ~cur_reg[76:0]};
  endtask
endmodule

// ===== dv/dvd_core_checker.sv
// Assertions on the event outputs of the value and branch debug block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module dvd_core_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pipeline side
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [2:0] acc_size,
  input wire logic acc_cache_op,
  input wire logic acc_no_reserve,
  input wire logic acc_string_empty,
  input wire logic addr_hit1,
  input wire logic addr_hit2,
  input wire logic br_valid,
  input wire logic br_taken,
  input wire logic [31:0] br_pc,
  // Event outputs
  input wire logic data_value_match1,
  input wire logic data_value_match2,
  input wire logic value_precise,
  input wire logic taken_branch_event,
  input wire logic branch_suppress,
  input wire logic stop_request,
  input wire logic debug_irq,
  input wire logic trace_event,
  input wire logic [31:0] critical_return_pc
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Either comparator fired
  wire any_match = data_value_match1 | data_value_match2;
  // ==========================================================
  // Value events
  property p_hit1;
    data_value_match1 |-> $past(acc_valid && addr_hit1);
  endproperty
  a_hit1: assert property (p_hit1)
    else $error("value event 1 without access and address hit");
  property p_hit2;
    data_value_match2 |-> $past(acc_valid && addr_hit2);
  endproperty
  a_hit2: assert property (p_hit2)
    else $error("value event 2 without access and address hit");
  property p_cache;
    acc_valid && acc_cache_op |=> !any_match;
  endproperty
  a_cache: assert property (p_cache)
    else $error("value event on a cache operation");
  property p_resv;
    acc_valid && acc_write && acc_no_reserve |=> !any_match;
  endproperty
  a_resv: assert property (p_resv)
    else $error("value event on a store without reservation");
  property p_empty;
    acc_valid && acc_string_empty |=> !any_match;
  endproperty
  a_empty: assert property (p_empty)
    else $error("value event on an empty string access");
  property p_size0;
    acc_valid && acc_size == 3'h0 |=> !any_match;
  endproperty
  a_size0: assert property (p_size0)
    else $error("value event with no byte transferred");
  property p_precise;
    value_precise |-> any_match;
  endproperty
  a_precise: assert property (p_precise)
    else $error("precise flag without a value event");
  // ==========================================================
  // Branch events
  property p_branch;
    taken_branch_event |-> $past(br_valid && br_taken);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch event without a taken branch");
  property p_stop;
    stop_request |-> taken_branch_event && branch_suppress && !debug_irq;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop without suppressed branch event");
  property p_irq;
    debug_irq |-> branch_suppress && critical_return_pc == $past(br_pc);
  endproperty
  a_irq: assert property (p_irq)
    else $error("debug irq without suppress or saved branch address");
  property p_trace;
    trace_event |-> taken_branch_event;
  endproperty
  a_trace: assert property (p_trace)
    else $error("trace pulse without branch event");
  // Main scenarios reached
  c_match: cover property (data_value_match1 && data_value_match2);
  c_stop: cover property (stop_request);
  c_irq: cover property (debug_irq);
  c_trace: cover property (trace_event);
endmodule

bind dvd_core dvd_core_checker chk (.aclk, .aresetn, .acc_valid,
  .acc_write, .acc_size, .acc_cache_op, .acc_no_reserve, .acc_string_empty,
  .addr_hit1, .addr_hit2, .br_valid, .br_taken, .br_pc,
  .data_value_match1, .data_value_match2, .value_precise,
  .taken_branch_event, .branch_suppress, .stop_request, .debug_irq,
  .trace_event, .critical_return_pc);

// ===== dv/tb.sv
// Self-checking bench for the value compare and taken-branch block.
// Assumes dvd_pkg, dvd_core, the pipeline model and checker come first.
`timescale 1ns/1ps
module tb
  import dvd_pkg::*;
;
  // ==========================================================
  // Signals
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, acc_offset;
  logic [31:0] s_axi_rdata, acc_data, br_pc, critical_return_pc;
  logic [2:0] acc_size;
  logic acc_valid, acc_write, acc_zero_line, acc_cache_op, acc_no_reserve;
  logic acc_string_empty, addr_hit1, addr_hit2, br_valid, br_taken;
  logic break_irq_allow = 1'h0;
  logic data_value_match1, data_value_match2, value_precise;
  logic taken_branch_event, branch_suppress, stop_request, debug_irq;
  logic trace_event;
  int n_mismatch = 0, checks = 0, cyc = 0;
  integer seed = 32'hD069;
  logic [33:0] qb[$];
  logic [39:0] qe[$];
  logic [31:0] ref1, ref2, crp = '0;
  logic [12:0] c2;
  logic [4:0] c0, st = 5'h00;
  logic ev_due = 1'h0;
  logic [4:0] tbl[5] = '{5'h03, 5'h05, 5'h09, 5'h11, 5'h08};
  logic [7:0] ofs[5] = '{OFS_CTRL0, OFS_CTRL2, OFS_REF1, OFS_REF2,
                         OFS_STATUS};

  // Free-running core clock, 40 ns period
  always #20 aclk = ~aclk;

  dvd_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc_write,
    .acc_offset, .acc_size, .acc_data, .acc_zero_line, .acc_cache_op,
    .acc_no_reserve, .acc_string_empty, .addr_hit1, .addr_hit2, .br_valid,
    .br_taken, .br_pc, .break_irq_allow, .data_value_match1,
    .data_value_match2, .value_precise, .taken_branch_event,
    .branch_suppress, .stop_request, .debug_irq, .trace_event,
    .critical_return_pc);
  dvd_pipe_model pipe (.aclk, .acc_valid, .br_valid, .acc_write,
    .acc_offset, .acc_size, .acc_zero_line, .acc_cache_op, .acc_no_reserve,
    .acc_string_empty, .addr_hit1, .addr_hit2, .br_taken, .acc_data,
    .br_pc);

  // ==========================================================
  // Compare and report
  task cmp_bus(input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task cmp_ev(input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task test_done;
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Bus master: holds each channel until its own handshake
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    qb.push_back({r, 32'h0});
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) ad = 1'h1;
      if (s_axi_wready) wd = 1'h1;
      if (ad) s_axi_awvalid <= 1'h0;
      if (wd) s_axi_wvalid <= 1'h0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    qb.push_back(e);
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  // ==========================================================
  // Expected value match of one comparator
  function automatic logic vm(input logic [31:0] rf, input logic [3:0] en,
    input logic [1:0] md, input logic [31:0] d, input logic [1:0] o,
    input logic [2:0] s);
    logic [3:0] m;
    for (int i = 0; i < 4; i++)
      m[i] = i >= o && i < o + s && d[31-8*i -: 8] == rf[31-8*i -: 8];
    case (md)
      2'h1: return en != 4'h0 && (m & en) == en;
      2'h2: return (m & en) != 4'h0;
      2'h3: return (en[1:0] != 2'h0 && (m[1:0] & en[1:0]) == en[1:0]) ||
                   (en[3:2] != 2'h0 && (m[3:2] & en[3:2]) == en[3:2]);
      default: return 1'h0;
    endcase
  endfunction
  // One random pipeline cycle; data is often near a reference word
  task step;
    logic [31:0] r, r2, d;
    logic [3:0] sp;
    logic [2:0] s;
    logic [1:0] o;
    logic av, w, zl, g, m1, m2, ev, stp, irq;
    r = $random(seed);
    r2 = $random(seed);
    sp = r[9:6];
    zl = sp == 4'h1;
    w = r[0] | zl | sp == 4'h3;
    av = r[12] | !r[13];
    s = zl ? 3'h4 : (r[5:3] > 3'h4 ? 3'h4 : r[5:3]);
    o = zl ? 2'h0 : r[2:1];
    d = zl ? 32'h0 : (r[15] ? ref1 : ref2) ^ (r2 & {{8{r[16]}},
        {8{r[17]}}, {8{r[18]}}, {8{r[19]}}});
    g = av && sp != 4'h2 && sp != 4'h4 && !(w && sp == 4'h3);
    m1 = g && r[10] && vm(ref1, c2[3:0], c2[9:8], d, o, s);
    m2 = g && r[11] && vm(ref2, c2[7:4], c2[11:10], d, o, s);
    ev = c0[0] && r[13] && r[14] &&
         (c0[1] | c0[2] | (c0[3] & break_irq_allow) | c0[4]);
    stp = ev && (c0[1] | c0[2]);
    irq = ev && !stp && c0[3] && break_irq_allow;
    // Saved return address only moves on an irq-mode branch event
    crp = irq ? r2 : crp;
    qe.push_back({m1, m2, (m1 | m2) & !c2[12], ev, stp | irq, stp, irq,
                  ev & c0[4], crp});
    st = st | {ev, m2 & w, m2 & !w, m1 & w, m1 & !w};
    pipe.put({av, r[13], w, o, s, zl, sp == 4'h2, sp == 4'h3, sp == 4'h4,
              r[10], r[11], r[14], d, r2});
  endtask

  // ==========================================================
  // Watcher: each answer takes the oldest expectation
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      cmp_bus(qb.pop_front(), {s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready)
      cmp_bus(qb.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (ev_due)
      cmp_ev(qe.pop_front(), {data_value_match1, data_value_match2,
        value_precise, taken_branch_event, branch_suppress, stop_request,
        debug_irq, trace_event, critical_return_pc});
    ev_due <= acc_valid | br_valid;
  end
  // Hang guard, far above the some 1500 cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (ofs[i]) rd(ofs[i], {RESP_OKAY, RST_WORD});
    wr(OFS_CTRL0, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFS_CTRL0, {RESP_OKAY, C0_MASK});
    wr(OFS_CTRL2, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFS_CTRL2, {RESP_OKAY, C2_MASK});
    wr(8'h14, 32'hFFFFFFFF, RESP_SLVERR);
    rd(8'h14, {RESP_SLVERR, 32'h0});
    for (int b = 0; b < 48; b++) begin
      c0 = tbl[b % 5];
      c2 = 13'($random(seed));
      ref1 = $random(seed);
      ref2 = $random(seed);
      break_irq_allow <= b[3];
      wr(OFS_CTRL0, {27'h0, c0}, RESP_OKAY);
      wr(OFS_CTRL2, {19'h0, c2}, RESP_OKAY);
      wr(OFS_REF1, ref1, RESP_OKAY);
      wr(OFS_REF2, ref2, RESP_OKAY);
      rd(OFS_REF1, {RESP_OKAY, ref1});
      repeat (8) step();
      pipe.idle();
      rd(OFS_STATUS, {RESP_OKAY, 27'h0, st});
      wr(OFS_STATUS, 32'h0000001F, RESP_OKAY);
      st = 5'h00;
    end
    repeat (4) @(posedge aclk);
    test_done();
  end
endmodule
